/* pkg/cpu_int_pkg.sv */
package cpu_int_pkg;

    // Positions in the interrupt state register
    localparam int HALT_BIT = 31;
    localparam int SERIAL_BIT = 30;
    localparam int ERROR_BIT = 29;
    localparam int PERF_BIT = 28;
    localparam int SOFT_BIT = 27;
    localparam int DEV3_BIT = 26;
    localparam int DEV2_BIT = 25;
    localparam int TIMER_BIT = 24;
    localparam int DEV1_BIT = 23;
    localparam int DEV0_BIT = 22;
    localparam int CODE_LSB = 16;
    localparam int CODE_MSB = 20;
    localparam int SW_LSB = 1;
    localparam int SW_MSB = 15;

    // Interrupt codes; equal to the request level except for the timer
    localparam logic [4:0] HALT_CODE = 5'h1f;
    localparam logic [4:0] SERIAL_CODE = 5'h18;
    localparam logic [4:0] ERROR_CODE = 5'h1d;
    localparam logic [4:0] PERF_CODE = 5'h1b;
    localparam logic [4:0] SOFT_CODE = 5'h1a;
    localparam logic [4:0] DEV3_CODE = 5'h17;
    localparam logic [4:0] DEV2_CODE = 5'h16;
    localparam logic [4:0] DEV1_CODE = 5'h15;
    localparam logic [4:0] DEV0_CODE = 5'h14;
    localparam logic [4:0] TIMER_CODE = 5'h1c;
    localparam logic [4:0] TIMER_LEVEL = 5'h16;
    localparam logic [4:0] NO_CODE = 5'h00;

    // Microtest select code that routes the pending signal onto the microtest bus
    localparam logic [3:0] UTEST_PENDING_SEL = 4'h3;
    localparam int UTEST_WIDTH = 4;

    localparam logic [31:0] READ_RESET = 32'h0000_0000;
    localparam logic [14:0] SW_RESET = 15'h0000;

    typedef struct packed {
        logic valid;
        logic halt;
        logic [4:0] level;
        logic [4:0] code;
    } encode_type;

endpackage : cpu_int_pkg

/* hw/cpu_interrupt_section.sv */
// Summary of operation
// - Internal hard, soft and timer events set flops 29, 27, 24; write 1 clears.
// - Performance monitor event sets flop 28; microcode writing 1 clears it.
// - Software bits 15..1 load from write bus; zeros drop their requests.
// - Bit 0 absent; timer request at bit 24 feeds encoder ungated.
// - Bits 31..22 and 15..1 feed encoder; software bits readable on bus.
// - Priority-encode pending bits into one request level and one code.
// - Pending raised when level above priority input, or halt always.
// - Pending drives microsequencer and is selectable on the microtest bus.
// - State read places code in bits 20..16 beside software bits.
// - Code equals level except timer: level 16 hex, code 1C hex.
// - Fixed source to bit and code mapping for all hardware sources.
// - Device lines never cleared by write; software clear 0; others clear 1.
// - Code reads 00 when nothing pending or top non-halt request not above priority level.
// - Software bits are read-write and zero after reset.
// - Code field is read-only; writes to it are ignored.
// - Writing 1 to bit 24 clears timer request; 0 does nothing.
// - Writing 1 to bit 28 clears performance request; 0 does nothing.
// - Bits 30, 28, 27, 24 always read as zero.
// - Six external request inputs pass a two-flop synchroniser.
// - Device line 2 beats the interval timer at level 16 hex.
`timescale 1ns/100ps

module cpu_interrupt_section (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic haltReq,
    input wire logic errorReq,
    input wire logic [3:0] deviceReq,
    input wire logic cacheHardErr,
    input wire logic serialLineReq,
    input wire logic cacheSoftErr,
    input wire logic instrSoftErr,
    input wire logic memSoftErr,
    input wire logic intervalTimerReq,
    input wire logic perfMonitorReq,
    input wire logic [4:0] processorStatusLevel,
    input wire logic stateWriteSelect,
    input wire logic diagStateWrite,
    input wire logic [31:0] writeDataBus,
    input wire logic stateReadSelect,
    input wire logic [cpu_int_pkg::UTEST_WIDTH-1:0] microtestSelect,
    output logic [31:0] operandReadBus,
    output logic interruptPending,
    output logic microtestBus
);
    import cpu_int_pkg::*;

    typedef struct packed {
        logic [5:0] syncFirst;
        logic [5:0] syncSecond;
        logic haltFlag;
        logic serialFlag;
        logic errorFlag;
        logic perfFlag;
        logic softFlag;
        logic timerFlag;
        logic [3:0] deviceLatch;
        logic [14:0] softwareRequestBits;
        logic [31:0] readData;
        logic pending;
        logic microtest;
    } state_type;

    state_type state;
    state_type next_state;
    logic [31:0] clearMask;
    logic [31:0] interruptStateReg;
    encode_type encoded;
    logic granted;

    // Lowest priority first; each later hit overrides, so the last one stands
    function automatic encode_type encode(input logic [31:0] interrupt_state_reg);
        encode_type r;
        r = '{valid: 1'b0, halt: 1'b0, level: NO_CODE, code: NO_CODE};
        for (int i = SW_LSB; i <= SW_MSB; i++) begin
            if (interrupt_state_reg[i]) begin
                r = '{valid: 1'b1, halt: 1'b0, level: 5'(i), code: 5'(i)};
            end
        end
        if (interrupt_state_reg[DEV0_BIT]) begin
            r = '{valid: 1'b1, halt: 1'b0, level: DEV0_CODE, code: DEV0_CODE};
        end
        if (interrupt_state_reg[DEV1_BIT]) begin
            r = '{valid: 1'b1, halt: 1'b0, level: DEV1_CODE, code: DEV1_CODE};
        end
        // Timer code differs from its level
        if (interrupt_state_reg[TIMER_BIT]) begin
            r = '{valid: 1'b1, halt: 1'b0, level: TIMER_LEVEL, code: TIMER_CODE};
        end
        // Device line 2 placed after the timer so it wins the shared level
        if (interrupt_state_reg[DEV2_BIT]) begin
            r = '{valid: 1'b1, halt: 1'b0, level: DEV2_CODE, code: DEV2_CODE};
        end
        if (interrupt_state_reg[DEV3_BIT]) begin
            r = '{valid: 1'b1, halt: 1'b0, level: DEV3_CODE, code: DEV3_CODE};
        end
        if (interrupt_state_reg[SERIAL_BIT]) begin
            r = '{valid: 1'b1, halt: 1'b0, level: SERIAL_CODE, code: SERIAL_CODE};
        end
        if (interrupt_state_reg[SOFT_BIT]) begin
            r = '{valid: 1'b1, halt: 1'b0, level: SOFT_CODE, code: SOFT_CODE};
        end
        if (interrupt_state_reg[PERF_BIT]) begin
            r = '{valid: 1'b1, halt: 1'b0, level: PERF_CODE, code: PERF_CODE};
        end
        if (interrupt_state_reg[ERROR_BIT]) begin
            r = '{valid: 1'b1, halt: 1'b0, level: ERROR_CODE, code: ERROR_CODE};
        end
        if (interrupt_state_reg[HALT_BIT]) begin
            r = '{valid: 1'b1, halt: 1'b1, level: HALT_CODE, code: HALT_CODE};
        end
        return r;
    endfunction : encode

    always_comb begin
        next_state = state;
        // Diagnostic path reaches only the write-one-to-clear bits
        clearMask = (stateWriteSelect || diagStateWrite)
            ? writeDataBus : 32'h0000_0000;

        next_state.syncFirst = {haltReq, errorReq, deviceReq};
        next_state.syncSecond = state.syncFirst;

        // New events win over a clear in the same cycle
        next_state.haltFlag = state.syncSecond[5]
            | (state.haltFlag & ~clearMask[HALT_BIT]);
        next_state.errorFlag = state.syncSecond[4] | cacheHardErr
            | (state.errorFlag & ~clearMask[ERROR_BIT]);
        next_state.serialFlag = serialLineReq
            | (state.serialFlag & ~clearMask[SERIAL_BIT]);
        next_state.softFlag = cacheSoftErr | instrSoftErr | memSoftErr
            | (state.softFlag & ~clearMask[SOFT_BIT]);
        next_state.timerFlag = intervalTimerReq
            | (state.timerFlag & ~clearMask[TIMER_BIT]);
        next_state.perfFlag = perfMonitorReq
            | (state.perfFlag & ~clearMask[PERF_BIT]);

        // Device latches are level followers; no write reaches them
        next_state.deviceLatch = state.syncSecond[3:0];

        // Only bits 15..1 are stored; the code field and clear bits are dropped
        if (stateWriteSelect) begin
            next_state.softwareRequestBits = writeDataBus[SW_MSB:SW_LSB];
        end

        interruptStateReg = 32'h0000_0000;
        interruptStateReg[HALT_BIT] = state.haltFlag;
        interruptStateReg[SERIAL_BIT] = state.serialFlag;
        interruptStateReg[ERROR_BIT] = state.errorFlag;
        interruptStateReg[PERF_BIT] = state.perfFlag;
        interruptStateReg[SOFT_BIT] = state.softFlag;
        interruptStateReg[DEV3_BIT] = state.deviceLatch[3];
        interruptStateReg[DEV2_BIT] = state.deviceLatch[2];
        interruptStateReg[TIMER_BIT] = state.timerFlag;
        interruptStateReg[DEV1_BIT] = state.deviceLatch[1];
        interruptStateReg[DEV0_BIT] = state.deviceLatch[0];
        interruptStateReg[SW_MSB:SW_LSB] = state.softwareRequestBits;

        encoded = encode(interruptStateReg);
        granted = encoded.valid
            && (encoded.halt || (encoded.level > processorStatusLevel));
        next_state.pending = granted;
        next_state.microtest = (microtestSelect == UTEST_PENDING_SEL) && granted;

        // Only the code and software bits appear; clear bits read as zero
        next_state.readData = READ_RESET;
        if (stateReadSelect) begin
            next_state.readData[CODE_MSB:CODE_LSB] = granted ? encoded.code
                : NO_CODE;
            next_state.readData[SW_MSB:SW_LSB] = state.softwareRequestBits;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= '{syncFirst: 6'h00, syncSecond: 6'h00, haltFlag: 1'b0,
                serialFlag: 1'b0, errorFlag: 1'b0, perfFlag: 1'b0, softFlag: 1'b0,
                timerFlag: 1'b0, deviceLatch: 4'h0, softwareRequestBits: SW_RESET,
                readData: READ_RESET, pending: 1'b0, microtest: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign operandReadBus = state.readData;
    assign interruptPending = state.pending;
    assign microtestBus = state.microtest;

    timerClear_a: assert property (@(posedge ref_clk) disable iff (rst)
        (stateWriteSelect && writeDataBus[TIMER_BIT] && !intervalTimerReq)
        |=> !state.timerFlag)
        else $error("timer request not cleared by write of one");

    perfSticky_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state.perfFlag && !perfMonitorReq && !stateWriteSelect && !diagStateWrite)
        |=> state.perfFlag)
        else $error("performance request lost without a clear");

    swLoad_a: assert property (@(posedge ref_clk) disable iff (rst)
        stateWriteSelect |=> state.softwareRequestBits == $past(writeDataBus[SW_MSB:SW_LSB]))
        else $error("software bits not loaded from write bus");

    diagKeepsSw_a: assert property (@(posedge ref_clk) disable iff (rst)
        (diagStateWrite && !stateWriteSelect) |=> $stable(state.softwareRequestBits))
        else $error("diagnostic write changed software bits");

    clearBitsZero_a: assert property (@(posedge ref_clk) disable iff (rst)
        ##1 (operandReadBus[SERIAL_BIT] == 1'b0 && operandReadBus[PERF_BIT] == 1'b0
        && operandReadBus[SOFT_BIT] == 1'b0 && operandReadBus[TIMER_BIT] == 1'b0))
        else $error("write-one-to-clear bit read as one");

    haltPending_a: assert property (@(posedge ref_clk) disable iff (rst)
        state.haltFlag |=> interruptPending)
        else $error("halt request did not raise pending");

    codeZero_a: assert property (@(posedge ref_clk) disable iff (rst)
        (stateReadSelect && !granted) |=> operandReadBus[CODE_MSB:CODE_LSB] == NO_CODE)
        else $error("nonzero code with nothing above priority level");

    timerCode_a: assert property (@(posedge ref_clk) disable iff (rst)
        (stateReadSelect && granted && interruptStateReg[31:25] == 7'h00
        && state.timerFlag) |=> operandReadBus[CODE_MSB:CODE_LSB] == TIMER_CODE)
        else $error("timer reported wrong code");

    haltSync_a: assert property (@(posedge ref_clk) disable iff (rst)
        haltReq [*3] |=> state.haltFlag)
        else $error("halt line not latched after two-flop delay");

    deviceFollow_a: assert property (@(posedge ref_clk) disable iff (rst)
        ##1 state.deviceLatch == $past(state.syncSecond[3:0]))
        else $error("device latch does not follow synchronised line");

    serialClear_a: assert property (@(posedge ref_clk) disable iff (rst)
        (stateWriteSelect && writeDataBus[SERIAL_BIT] && !serialLineReq) |=> !state.serialFlag)
        else $error("serial request not cleared by write of one");

    softClear_a: assert property (@(posedge ref_clk) disable iff (rst)
        (stateWriteSelect && writeDataBus[SOFT_BIT] && !(cacheSoftErr || instrSoftErr
        || memSoftErr)) |=> !state.softFlag)
        else $error("soft error request not cleared by write of one");

    perfClear_a: assert property (@(posedge ref_clk) disable iff (rst)
        (stateWriteSelect && writeDataBus[PERF_BIT] && !perfMonitorReq) |=> !state.perfFlag)
        else $error("performance request not cleared by write of one");

    perfSet_a: assert property (@(posedge ref_clk) disable iff (rst)
        perfMonitorReq |=> state.perfFlag)
        else $error("performance event did not set its request");

    timerSet_a: assert property (@(posedge ref_clk) disable iff (rst)
        intervalTimerReq |=> state.timerFlag)
        else $error("timer event did not set its request");

    softSet_a: assert property (@(posedge ref_clk) disable iff (rst)
        (cacheSoftErr || instrSoftErr || memSoftErr) |=> state.softFlag)
        else $error("soft error event did not set its request");

    errorSet_a: assert property (@(posedge ref_clk) disable iff (rst)
        cacheHardErr |=> state.errorFlag)
        else $error("hard error event did not set the error request");

    timerSticky_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state.timerFlag && !((stateWriteSelect || diagStateWrite) && writeDataBus[TIMER_BIT]))
        |=> state.timerFlag)
        else $error("timer request lost without a clear");

    swHold_a: assert property (@(posedge ref_clk) disable iff (rst)
        !stateWriteSelect |=> $stable(state.softwareRequestBits))
        else $error("software bits changed without a write");

    haltClear_a: assert property (@(posedge ref_clk) disable iff (rst)
        (stateWriteSelect && writeDataBus[HALT_BIT] && !state.syncSecond[5])
        |=> !state.haltFlag)
        else $error("halt request not cleared by write of one");

    softPending_a: assert property (@(posedge ref_clk) disable iff (rst)
        (interruptStateReg[31:16] == 16'h0000 && state.softwareRequestBits[SW_MSB - SW_LSB]
        && processorStatusLevel < 5'(SW_MSB)) |=> interruptPending)
        else $error("software request above priority level not pending");

    noPendingLow_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!state.haltFlag && processorStatusLevel == HALT_CODE) |=> !interruptPending)
        else $error("pending raised at top priority level without halt");

    idleNoPending_a: assert property (@(posedge ref_clk) disable iff (rst)
        interruptStateReg == 32'h0000_0000 |=> !interruptPending)
        else $error("pending raised with no request");

    readIdle_a: assert property (@(posedge ref_clk) disable iff (rst)
        !stateReadSelect |=> operandReadBus == READ_RESET)
        else $error("read bus not idle without a read");

    readSw_a: assert property (@(posedge ref_clk) disable iff (rst)
        stateReadSelect |=> operandReadBus[SW_MSB:SW_LSB] == $past(state.softwareRequestBits))
        else $error("software bits not returned on read");

    unusedZero_a: assert property (@(posedge ref_clk) disable iff (rst)
        ##1 (operandReadBus[0] == 1'b0 && operandReadBus[31:21] == 11'h000))
        else $error("unused read bit read as one");

    utestIdle_a: assert property (@(posedge ref_clk) disable iff (rst)
        microtestSelect != UTEST_PENDING_SEL |=> !microtestBus)
        else $error("microtest bus driven without its select");

    utestPending_a: assert property (@(posedge ref_clk) disable iff (rst)
        microtestSelect == UTEST_PENDING_SEL |=> microtestBus == interruptPending)
        else $error("microtest bus does not show pending");

    devTwoWins_a: assert property (@(posedge ref_clk) disable iff (rst)
        (stateReadSelect && interruptStateReg[31:26] == 6'h00 && state.deviceLatch[2]
        && state.timerFlag && processorStatusLevel < DEV2_CODE)
        |=> operandReadBus[CODE_MSB:CODE_LSB] == DEV2_CODE)
        else $error("timer beat device line 2 at shared level");

    haltCode_a: assert property (@(posedge ref_clk) disable iff (rst)
        (stateReadSelect && state.haltFlag) |=> operandReadBus[CODE_MSB:CODE_LSB] == HALT_CODE)
        else $error("halt reported wrong code");

endmodule : cpu_interrupt_section

/* test/microcode_model.sv */
`timescale 1ns/100ps

module microcode_model (
    input wire logic ref_clk,
    input wire logic [31:0] operandReadBus,
    output logic stateWriteSelect,
    output logic diagStateWrite,
    output logic stateReadSelect,
    output logic [31:0] writeDataBus
);
    int cyc = 0;
    int lastWr = -8;
    initial begin
        stateWriteSelect = 1'b0;
        diagStateWrite = 1'b0;
        stateReadSelect = 1'b0;
        writeDataBus = 32'h0;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
    end
    task automatic wr(input logic [31:0] d, input logic diag);
        @(posedge ref_clk);
        stateWriteSelect <= !diag;
        diagStateWrite <= diag;
        writeDataBus <= diag ? (d & 32'hf900_0000) : d;
        @(posedge ref_clk);
        lastWr = cyc;
        stateWriteSelect <= 1'b0;
        diagStateWrite <= 1'b0;
        // Released bus shows the inverse so stale data cannot pass
        writeDataBus <= ~writeDataBus;
    endtask : wr
    task automatic rd(output logic [31:0] d);
        while (cyc - lastWr < 4) @(posedge ref_clk);
        @(posedge ref_clk);
        stateReadSelect <= 1'b1;
        @(posedge ref_clk);
        stateReadSelect <= 1'b0;
        #1 d = operandReadBus;
    endtask : rd
endmodule : microcode_model

/* test/tb_top.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errorCnt++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end

module tb_top;
    import cpu_int_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic haltReq = 1'b0;
    logic errorReq = 1'b0;
    logic [3:0] deviceReq = 4'h0;
    logic [6:0] ev = 7'h00;
    logic [4:0] prio = 5'h00;
    logic [3:0] microtestSelect = 4'h0;
    logic stateWriteSelect, diagStateWrite, stateReadSelect, interruptPending, microtestBus;
    logic [31:0] writeDataBus, operandReadBus;
    int errorCnt = 0;
    int checked = 0;
    int cycles = 0;
    int bitPos[7] = '{30, 29, 28, 27, 27, 27, 24};
    logic [4:0] evCode[7] = '{5'h18, 5'h1d, 5'h1b, 5'h1a, 5'h1a, 5'h1a, 5'h1c};
    logic [4:0] devCode[4] = '{5'h14, 5'h15, 5'h16, 5'h17};

    always #2 ref_clk = ~ref_clk;

    cpu_interrupt_section cpu_interrupt_section_inst (.ref_clk(ref_clk), .rst(rst),
        .haltReq(haltReq), .errorReq(errorReq), .deviceReq(deviceReq),
        .serialLineReq(ev[6]), .cacheHardErr(ev[5]), .perfMonitorReq(ev[4]),
        .cacheSoftErr(ev[3]), .instrSoftErr(ev[2]), .memSoftErr(ev[1]),
        .intervalTimerReq(ev[0]), .processorStatusLevel(prio),
        .stateWriteSelect(stateWriteSelect), .diagStateWrite(diagStateWrite),
        .writeDataBus(writeDataBus), .stateReadSelect(stateReadSelect),
        .microtestSelect(microtestSelect), .operandReadBus(operandReadBus),
        .interruptPending(interruptPending), .microtestBus(microtestBus));

    microcode_model microcode_model_inst (.ref_clk(ref_clk), .operandReadBus(operandReadBus),
        .stateWriteSelect(stateWriteSelect), .diagStateWrite(diagStateWrite),
        .stateReadSelect(stateReadSelect), .writeDataBus(writeDataBus));

    task automatic results;
        if (errorCnt == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : idle

    task automatic expectRead(input logic [4:0] code, input logic [15:0] sw, input logic pend);
        logic [31:0] d;
        microcode_model_inst.rd(d);
        `CHK(d, {11'h0, code, sw})
        `CHK(interruptPending, pend)
        @(posedge ref_clk);
    endtask : expectRead

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 8000) begin
            errorCnt++;
            results();
        end
    end

    initial begin
        idle(8);
        rst <= 1'b0;
        expectRead(5'h00, 16'h0000, 1'b0);
        for (int i = 1; i < 16; i++) begin
            // Ones into the code field must be ignored
            microcode_model_inst.wr(32'h001f_0000 | (32'h1 << i), 1'b0);
            expectRead(5'(i), 16'(1 << i), 1'b1);
        end
        microcode_model_inst.wr(32'h0000_8006, 1'b0);
        prio <= 5'h0f;
        expectRead(5'h00, 16'h8006, 1'b0);
        prio <= 5'h0e;
        idle(4);
        expectRead(5'h0f, 16'h8006, 1'b1);
        prio <= 5'h00;
        microcode_model_inst.wr(32'h0, 1'b0);
        expectRead(5'h00, 16'h0000, 1'b0);
        for (int k = 0; k < 7; k++) begin
            ev <= 7'(7'h40 >> k);
            @(posedge ref_clk);
            ev <= 7'h00;
            microcode_model_inst.wr(32'h0, 1'b0);
            expectRead(evCode[k], 16'h0000, 1'b1);
            microcode_model_inst.wr(32'h1 << bitPos[k], 1'b0);
            expectRead(5'h00, 16'h0000, 1'b0);
        end
        ev <= 7'h01;
        @(posedge ref_clk);
        ev <= 7'h00;
        microcode_model_inst.wr(32'h2, 1'b0);
        microcode_model_inst.wr(32'hffff_ffff, 1'b1);
        expectRead(5'h01, 16'h0002, 1'b1);
        microcode_model_inst.wr(32'h0, 1'b0);
        prio <= 5'h1f;
        haltReq <= 1'b1;
        microtestSelect <= UTEST_PENDING_SEL;
        idle(6);
        haltReq <= 1'b0;
        #1 `CHK(microtestBus, 1'b1)
        @(posedge ref_clk);
        microtestSelect <= 4'h0;
        expectRead(5'h1f, 16'h0000, 1'b1);
        #1 `CHK(microtestBus, 1'b0)
        microcode_model_inst.wr(32'h8000_0000, 1'b0);
        prio <= 5'h00;
        errorReq <= 1'b1;
        idle(6);
        errorReq <= 1'b0;
        expectRead(5'h1d, 16'h0000, 1'b1);
        microcode_model_inst.wr(32'h2000_0000, 1'b0);
        for (int k = 0; k < 4; k++) begin
            deviceReq <= 4'(1 << k);
            microcode_model_inst.wr(32'hffff_0000, 1'b0);
            expectRead(devCode[k], 16'h0000, 1'b1);
            deviceReq <= 4'h0;
            idle(6);
            expectRead(5'h00, 16'h0000, 1'b0);
        end
        deviceReq <= 4'h4;
        ev <= 7'h01;
        @(posedge ref_clk);
        ev <= 7'h00;
        // Device line needs its two sync stages and latch before the read
        idle(4);
        expectRead(5'h16, 16'h0000, 1'b1);
        deviceReq <= 4'h0;
        idle(6);
        expectRead(TIMER_CODE, 16'h0000, 1'b1);
        microcode_model_inst.wr(32'h0100_0000, 1'b0);
        expectRead(5'h00, 16'h0000, 1'b0);
        results();
    end
endmodule : tb_top
